/* File: logic/mdfs_supervisor.sv */
// fault supervision, pwm timebase and periodic ticks for the motor drive
`timescale 1ns/1ps
`include "mdfs_regs.svh"

module mdfs_supervisor
    import mdfs_pkg::*;
#(
    parameter logic [15:0] PWM_MODULUS = `MDFS_PWM_MODULUS,
    parameter logic [7:0] UV_COUNT = `MDFS_UV_COUNT,
    parameter logic [7:0] OT_COUNT = `MDFS_OT_COUNT,
    parameter logic [15:0] IND_PERIOD = `MDFS_IND_PERIOD,
    parameter logic [15:0] RAMP_PERIOD = `MDFS_RAMP_PERIOD
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // power stage fault pins, asynchronous
    input wire logic overcurrentFaultInput,
    input wire logic overvoltageFaultInput,
    // board identification result
    input wire logic identDone,
    input wire logic identMatch,
    // adc scan
    input wire logic scanDone,
    input wire mdfs_scan_type scan,
    input wire mdfs_limits_type limits,
    // duty values from waveform math
    input wire logic [15:0] dutyA,
    input wire logic [15:0] dutyB,
    input wire logic [15:0] dutyC,
    // outputs
    output logic [5:0] inverterDriveOutputs,
    output logic [4:0] driveFaultFlags,
    output logic faultIndicator,
    output logic runIndicator,
    output logic brakeOn,
    output logic reloadEvent,
    output logic adcStart,
    output logic indicatorTick,
    output logic rampTick,
    output logic watchdogSupervisorEnable,
    output logic lowSupplyDetectorEnable
);
    // refuse settings the counters cannot serve
    if (PWM_MODULUS < 16'h0002 || UV_COUNT == 8'h00 || OT_COUNT == 8'h00 ||
        IND_PERIOD == 16'h0000 || RAMP_PERIOD == 16'h0000) begin : g_param_check
        $error("mdfs_supervisor: parameter out of range");
    end

    function automatic logic [15:0] wrapInc(input logic [15:0] v, input logic [15:0] top);
        wrapInc = (v >= top - 16'h0001) ? 16'h0000 : v + 16'h0001;
    endfunction

    // pin synchronisers
    logic [1:0] ocSync_q, ovSync_q;
    logic ocPrev_q, ovPrev_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ocSync_q <= 2'b00;
            ovSync_q <= 2'b00;
            ocPrev_q <= 1'b0;
            ovPrev_q <= 1'b0;
        end else begin
            ocSync_q <= {ocSync_q[0], overcurrentFaultInput};
            ovSync_q <= {ovSync_q[0], overvoltageFaultInput};
            ocPrev_q <= ocSync_q[1];
            ovPrev_q <= ovSync_q[1];
        end
    end
    logic ocEdge, ovEdge;
    // rising edge of the synchronised pin picks which flag a fault event sets
    assign ocEdge = ocSync_q[1] & ~ocPrev_q;
    assign ovEdge = ovSync_q[1] & ~ovPrev_q;

    // persistence counters on each scan
    logic [7:0] uvCnt_q, otCnt_q;
    logic uvLow, otHigh, uvHit, otHit;
    assign uvLow = scan.busVoltage < limits.underVoltLimit;
    assign otHigh = scan.moduleTemp > limits.overTempLimit;
    assign uvHit = scanDone && uvLow && (uvCnt_q + 8'h01 >= UV_COUNT);
    assign otHit = scanDone && otHigh && (otCnt_q + 8'h01 >= OT_COUNT);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uvCnt_q <= 8'h00;
            otCnt_q <= 8'h00;
        end else if (scanDone) begin
            uvCnt_q <= uvLow ? ((uvCnt_q == 8'hff) ? uvCnt_q : uvCnt_q + 8'h01) : 8'h00;
            otCnt_q <= otHigh ? ((otCnt_q == 8'hff) ? otCnt_q : otCnt_q + 8'h01) : 8'h00;
        end
    end

    // application state
    mdfs_state_type state_q;
    logic [4:0] driveFaultFlags_d;
    logic wrongBoard;
    assign wrongBoard = (state_q == MDFS_IDENT) && identDone && !identMatch;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= MDFS_IDENT;
        end else begin
            case (state_q)
                MDFS_IDENT: state_q <= identDone ? (identMatch ? MDFS_RUN : MDFS_HALT) : MDFS_IDENT;
                MDFS_RUN: state_q <= (|driveFaultFlags_d) ? MDFS_HALT : MDFS_RUN;
                MDFS_HALT: state_q <= MDFS_HALT; // only reset leaves
                default: state_q <= MDFS_HALT;
            endcase
        end
    end

    // sticky flags
    always_comb begin
        driveFaultFlags_d = driveFaultFlags;
        if (ocEdge) driveFaultFlags_d[`MDFS_FLAG_OC] = 1'b1;
        if (ovEdge) driveFaultFlags_d[`MDFS_FLAG_OV] = 1'b1;
        if (uvHit) driveFaultFlags_d[`MDFS_FLAG_UV] = 1'b1;
        if (otHit) driveFaultFlags_d[`MDFS_FLAG_OT] = 1'b1;
        if (wrongBoard) driveFaultFlags_d[`MDFS_FLAG_WB] = 1'b1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) driveFaultFlags <= 5'h00;
        else driveFaultFlags <= driveFaultFlags_d;
    end

    logic pwmEnable;
    // disable is combinational off the edge so the gates close at once
    assign pwmEnable = (state_q == MDFS_RUN) && !(|driveFaultFlags_d);

    // centre-aligned up/down counter
    logic [15:0] pwmCnt_q;
    logic pwmDown_q;
    logic [2:0] periodCnt_q;
    logic periodEnd;
    assign periodEnd = pwmDown_q && (pwmCnt_q == 16'h0001);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwmCnt_q <= 16'h0000;
            pwmDown_q <= 1'b0;
        end else if (pwmDown_q) begin
            pwmCnt_q <= pwmCnt_q - 16'h0001;
            pwmDown_q <= (pwmCnt_q != 16'h0001);
        end else begin
            pwmCnt_q <= pwmCnt_q + 16'h0001;
            pwmDown_q <= (pwmCnt_q + 16'h0001 == PWM_MODULUS);
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            periodCnt_q <= 3'h0;
            reloadEvent <= 1'b0;
        end else begin
            reloadEvent <= 1'b0;
            if (periodEnd) begin
                if (periodCnt_q == `MDFS_RELOAD_DIV - 3'h1) begin
                    periodCnt_q <= 3'h0;
                    reloadEvent <= 1'b1;
                end else begin
                    periodCnt_q <= periodCnt_q + 3'h1;
                end
            end
        end
    end

    // duty shadow loads on reload, adc start one cycle later
    logic [15:0] dutyA_q, dutyB_q, dutyC_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dutyA_q <= 16'h0000;
            dutyB_q <= 16'h0000;
            dutyC_q <= 16'h0000;
            adcStart <= 1'b0;
        end else begin
            adcStart <= reloadEvent && (state_q == MDFS_RUN);
            if (reloadEvent) begin
                dutyA_q <= dutyA;
                dutyB_q <= dutyB;
                dutyC_q <= dutyC;
            end
        end
    end
    logic [2:0] phaseHigh_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) phaseHigh_q <= 3'b000;
        else phaseHigh_q <= {pwmCnt_q < dutyC_q, pwmCnt_q < dutyB_q, pwmCnt_q < dutyA_q};
    end
    // complementary pairs, positive polarity, forced low when disabled
    assign inverterDriveOutputs = pwmEnable ?
        {~phaseHigh_q[2], phaseHigh_q[2], ~phaseHigh_q[1], phaseHigh_q[1],
         ~phaseHigh_q[0], phaseHigh_q[0]} : 6'h00;

    // brake hysteresis
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) brakeOn <= 1'b0;
        else if (scanDone && scan.busVoltage > limits.brakeHighLimit) brakeOn <= 1'b1;
        else if (scanDone && scan.busVoltage < limits.brakeLowLimit) brakeOn <= 1'b0;
    end

    // periodic ticks
    logic [15:0] indCnt_q, rampCnt_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            indCnt_q <= 16'h0000;
            rampCnt_q <= 16'h0000;
            indicatorTick <= 1'b0;
            rampTick <= 1'b0;
        end else begin
            indCnt_q <= wrapInc(indCnt_q, IND_PERIOD);
            rampCnt_q <= wrapInc(rampCnt_q, RAMP_PERIOD);
            indicatorTick <= (indCnt_q == IND_PERIOD - 16'h0001);
            rampTick <= (rampCnt_q == RAMP_PERIOD - 16'h0001);
        end
    end

    // indicators
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            faultIndicator <= 1'b0;
            runIndicator <= 1'b0;
        end else begin
            faultIndicator <= (|driveFaultFlags_d) || (state_q == MDFS_HALT);
            runIndicator <= (state_q == MDFS_RUN) && !(|driveFaultFlags_d);
        end
    end

    assign watchdogSupervisorEnable = 1'b0;
    assign lowSupplyDetectorEnable = 1'b0;

    property p_oc_disable;
        @(posedge clk) disable iff (!arst_n)
        ocEdge |-> (inverterDriveOutputs == 6'h00) ##1 driveFaultFlags[`MDFS_FLAG_OC];
    endproperty
    a_oc_disable: assert property (p_oc_disable) else $error("oc edge not handled");
    property p_ov_disable;
        @(posedge clk) disable iff (!arst_n)
        ovEdge |-> (inverterDriveOutputs == 6'h00) ##1 driveFaultFlags[`MDFS_FLAG_OV];
    endproperty
    a_ov_disable: assert property (p_ov_disable) else $error("ov edge not handled");
    property p_uv_flag;
        @(posedge clk) disable iff (!arst_n)
        uvHit |=> driveFaultFlags[`MDFS_FLAG_UV] && inverterDriveOutputs == 6'h00;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("uv not flagged");
    property p_ot_flag;
        @(posedge clk) disable iff (!arst_n)
        otHit |=> driveFaultFlags[`MDFS_FLAG_OT] && inverterDriveOutputs == 6'h00;
    endproperty
    a_ot_flag: assert property (p_ot_flag) else $error("ot not flagged");
    property p_wrong_board;
        @(posedge clk) disable iff (!arst_n)
        wrongBoard |=> driveFaultFlags[`MDFS_FLAG_WB] && state_q == MDFS_HALT;
    endproperty
    a_wrong_board: assert property (p_wrong_board) else $error("wrong board not halted");
    property p_flags_sticky;
        @(posedge clk) disable iff (!arst_n)
        |driveFaultFlags |=> (driveFaultFlags & $past(driveFaultFlags)) == $past(driveFaultFlags);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) else $error("flag cleared");
    property p_halt_quiet;
        @(posedge clk) disable iff (!arst_n)
        state_q == MDFS_HALT |-> inverterDriveOutputs == 6'h00 ##1 faultIndicator;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("halt not quiet");
    property p_adc_after_reload;
        @(posedge clk) disable iff (!arst_n)
        adcStart |-> $past(reloadEvent) && dutyA_q == $past(dutyA);
    endproperty
    a_adc_after_reload: assert property (p_adc_after_reload) else $error("adc start unordered");
    property p_adc_run;
        @(posedge clk) disable iff (!arst_n)
        adcStart |-> $past(state_q) == MDFS_RUN;
    endproperty
    a_adc_run: assert property (p_adc_run) else $error("adc start outside run");
    property p_brake;
        @(posedge clk) disable iff (!arst_n)
        scanDone && scan.busVoltage > limits.brakeHighLimit |=> brakeOn;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not on");
    property p_complement;
        @(posedge clk) disable iff (!arst_n)
        pwmEnable |-> inverterDriveOutputs[0] != inverterDriveOutputs[1] &&
            inverterDriveOutputs[2] != inverterDriveOutputs[3] &&
            inverterDriveOutputs[4] != inverterDriveOutputs[5];
    endproperty
    a_complement: assert property (p_complement) else $error("pair not complementary");
endmodule

/* File: common/mdfs_regs.svh */
// constants for the motor drive fault supervisor
`ifndef MDFS_REGS_SVH
`define MDFS_REGS_SVH
`define MDFS_FLAG_OC 0
`define MDFS_FLAG_OV 1
`define MDFS_FLAG_UV 2
`define MDFS_FLAG_OT 3
`define MDFS_FLAG_WB 4
`define MDFS_NFLAGS 5
`define MDFS_RELOAD_DIV 3'h4
`define MDFS_UV_COUNT 8'h08
`define MDFS_OT_COUNT 8'h08
`define MDFS_IND_PERIOD 16'h1388
`define MDFS_RAMP_PERIOD 16'h2710
`define MDFS_PWM_MODULUS 16'h0271
`endif

/* File: common/mdfs_pkg.sv */
// types for the motor drive fault supervisor
package mdfs_pkg;
    typedef enum logic [1:0] {
        MDFS_IDENT = 2'b00,
        MDFS_RUN = 2'b01,
        MDFS_HALT = 2'b11
    } mdfs_state_type;

    typedef struct packed {
        logic [11:0] busVoltage;
        logic [11:0] busCurrent;
        logic [11:0] moduleTemp;
    } mdfs_scan_type;

    typedef struct packed {
        logic [11:0] underVoltLimit;
        logic [11:0] overTempLimit;
        logic [11:0] brakeHighLimit;
        logic [11:0] brakeLowLimit;
    } mdfs_limits_type;
endpackage

/* File: tb/mdfs_power_stage.sv */
// power stage and adc model: fault pins, board identification, scan results
`timescale 1ns/1ps
module mdfs_power_stage
    import mdfs_pkg::*;
(
    // clock
    input wire logic clk,
    // towards the supervisor
    output logic overcurrentFaultInput,
    output logic overvoltageFaultInput,
    output logic identDone,
    output logic identMatch,
    output logic scanDone,
    output mdfs_scan_type scan
);
    initial begin
        overcurrentFaultInput = 1'b0;
        overvoltageFaultInput = 1'b0;
        identDone = 1'b0;
        identMatch = 1'b0;
        scanDone = 1'b0;
        scan = '0;
    end
    // a fault is a rising edge on one pin, held until dropped
    task automatic raiseFault(input logic ov);
        @(posedge clk);
        if (ov) overvoltageFaultInput <= 1'b1;
        else overcurrentFaultInput <= 1'b1;
    endtask
    task automatic dropFaults();
        @(posedge clk);
        overvoltageFaultInput <= 1'b0;
        overcurrentFaultInput <= 1'b0;
    endtask
    // identification message, one strobe with the board result
    task automatic sendIdent(input logic match);
        @(posedge clk);
        identDone <= 1'b1;
        identMatch <= match;
        @(posedge clk);
        identDone <= 1'b0;
    endtask
    // scan result valid for one cycle; stale data is inverted so it cannot pass
    task automatic sendScan(input logic [11:0] v, c, t, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        scanDone <= 1'b1;
        scan <= {v, c, t};
        @(posedge clk);
        scanDone <= 1'b0;
        scan <= ~{v, c, t};
    endtask
endmodule

/* File: tb/mdfs_supervisor_test.sv */
// self-checking bench for the motor drive fault supervisor
`timescale 1ns/1ps
module mdfs_supervisor_test
    import mdfs_pkg::*;
;
    localparam logic [15:0] MOD = 16'h0004;
    localparam logic [15:0] TICK = 16'h0008;
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic ocPin, ovPin, identDone, identMatch, scanDone;
    mdfs_scan_type scan;
    mdfs_limits_type limits = '{12'h200, 12'h300, 12'hc00, 12'ha00};
    logic [15:0] duty = 16'h0002;
    logic [5:0] drive;
    logic [4:0] flags;
    logic faultInd, runInd, brakeOn, reloadEvent, adcStart, indTick, rampTick, wdEn, lvEn;
    logic seenDrive = 1'b0;
    logic [11:0] brakeV [4] = '{12'hd00, 12'hb00, 12'h900, 12'hb00};
    logic [3:0] brakeExp = 4'b0011;
    int errCount = 0;
    int nCompared = 0;
    int gap;
    wire [2:0] pulses = {reloadEvent, rampTick, indTick};
    always #25 clk = ~clk;
    // duty moves every clock so a late or early shadow capture is caught
    always @(posedge clk) duty <= duty ^ 16'h0003;
    mdfs_power_stage ps_u (.clk(clk), .overcurrentFaultInput(ocPin),
        .overvoltageFaultInput(ovPin), .identDone(identDone), .identMatch(identMatch),
        .scanDone(scanDone), .scan(scan));
    mdfs_supervisor #(.PWM_MODULUS(MOD), .UV_COUNT(8'h02), .OT_COUNT(8'h02),
        .IND_PERIOD(TICK), .RAMP_PERIOD(TICK)) dut_u (.clk(clk), .arst_n(rstN),
        .overcurrentFaultInput(ocPin), .overvoltageFaultInput(ovPin),
        .identDone(identDone), .identMatch(identMatch), .scanDone(scanDone), .scan(scan),
        .limits(limits), .dutyA(duty), .dutyB(duty), .dutyC(duty),
        .inverterDriveOutputs(drive), .driveFaultFlags(flags), .faultIndicator(faultInd),
        .runIndicator(runInd), .brakeOn(brakeOn), .reloadEvent(reloadEvent),
        .adcStart(adcStart), .indicatorTick(indTick), .rampTick(rampTick),
        .watchdogSupervisorEnable(wdEn), .lowSupplyDetectorEnable(lvEn));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic doReset(input logic match);
        @(posedge clk);
        rstN <= 1'b0;
        repeat (8) @(posedge clk);
        rstN <= 1'b1;
        ps_u.sendIdent(match);
        repeat (20) @(negedge clk);
    endtask
    // cycles between two pulses of one periodic output, bounded
    task automatic gapOf(input int which, output int n);
        int w;
        w = 0;
        while (pulses[which] !== 1'b1 && w < 200) begin
            @(negedge clk);
            w++;
        end
        n = 1;
        @(negedge clk);
        while (pulses[which] !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    // disable may leave a pair both low, never both high
    always @(negedge clk) begin
        if (drive != 6'h00) seenDrive <= 1'b1;
        if ((drive[0] & drive[1]) | (drive[2] & drive[3]) | (drive[4] & drive[5]))
            check("pair both on", 16'h0, 16'h1);
    end
    initial begin
        #(50 * 5000);
        errCount++;
        $display("[ERR] watchdog expected finish seen hang");
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstN <= 1'b1;
        @(negedge clk);
        check("flags after reset", 16'h0, 16'(flags));
        check("supervisors", 16'h0, 16'({wdEn, lvEn}));
        check("drive in ident", 16'h0, 16'(drive));
        ps_u.sendIdent(1'b1);
        repeat (2) @(negedge clk);
        check("run indicator", 16'h1, 16'(runInd));
        gapOf(2, gap);
        check("reload spacing", 16'(8 * MOD), 16'(gap));
        @(negedge clk);
        check("adc start", 16'h1, 16'(adcStart));
        gapOf(1, gap);
        check("ramp spacing", TICK, 16'(gap));
        gapOf(0, gap);
        check("indicator spacing", TICK, 16'(gap));
        check("drive seen", 16'h1, 16'(seenDrive));
        for (int i = 0; i < 4; i++) begin
            ps_u.sendScan(brakeV[i], 12'h100, 12'h100, i);
            repeat (2) @(negedge clk);
            check("brake", 16'(brakeExp[i]), 16'(brakeOn));
        end
        for (int k = 0; k < 2; k++) begin
            doReset(1'b1);
            ps_u.raiseFault(k[0]);
            // edge reaches the gates two clocks after the pin, flag one clock later
            repeat (3) @(negedge clk);
            check("drive cut", 16'h0, 16'(drive));
            @(negedge clk);
            check("pin flag", 16'(1 << k), 16'(flags));
            ps_u.dropFaults();
            repeat (6) @(negedge clk);
            check("flag held", 16'(1 << k), 16'(flags));
            check("indicators", 16'h2, 16'({faultInd, runInd}));
        end
        for (int k = 0; k < 2; k++) begin
            doReset(1'b1);
            for (int s = 0; s < 4; s++) begin
                ps_u.sendScan((s == 1 || k) ? 12'h800 : 12'h100, 12'h100,
                    (s != 1 && k) ? 12'h400 : 12'h100, s);
                repeat (2) @(negedge clk);
                check("persist flag", s == 3 ? 16'(4 << k) : 16'h0, 16'(flags));
            end
            check("drive off", 16'h0, 16'(drive));
        end
        doReset(1'b0);
        check("wrong board", 16'h10, 16'(flags));
        ps_u.sendIdent(1'b1);
        repeat (3) @(negedge clk);
        check("halt held", 16'h2, 16'({faultInd, runInd}));
        check("halt drive", 16'h0, 16'(drive));
        summarize();
    end
endmodule
